// File: src/eeprom_shadow_map.vh
// Function
// (RL1) Power-up copies nonvolatile fields into shadow
// (RL2) Shadow sits 0x40 above nonvolatile address
// (RL3) Unused bits absent, read zero, no check bits
// (RL4) Shadow writes protected alike; reads always allowed
// (RL5) Key 00,27,81,1F,77 into key byte unlocks
// (RL6) Nonvolatile reads always served
// (RL7) Margin check needs unlocked device
// (RL8) Lock code 0xC blocks nonvolatile writes only
// (RL9) Lock code 0x3 blocks nonvolatile and shadow
// (RL10) Host loads address, then data, then triggers
// (RL11) Go bit 0x80 starts write to address
// (RL12) Nonvolatile write up to 24 ms, done flag
// (RL13) Shadow write completes in one cycle
// (RL14) Host polls done bit 0 of status
// (RL15) Violation ends transaction, sets done, warning
// (RL16) Error bit set when nonvolatile write aborts
// (RL17) Threshold 0001 lowers sense threshold
// (RL18) Threshold 0010 raises sense threshold
// (RL19) Margin setting persists and reads back
// (RL20) Threshold applies only after 0xA5 confirm
// (RL21) Threshold 0000 or reset restores normal
// (RL22) Host verifies at both thresholds, rewrites
// (RL23) Read: address, read go, then data
// (RL24) Nonvolatile read up to 2 us, done flag
// (RL25) Other lock codes leave writes permitted
// (RL26) Trigger clears done; reset clears unlock
//
// Purpose: register map and constants of the extended access block
// Assumes: byte-wide register port, 16-bit registers, even byte = MSB
// Notes: definitions only
`ifndef EEPROM_SHADOW_MAP_VH
`define EEPROM_SHADOW_MAP_VH
`define A_EWA_LO 7'h03
`define A_EWDH_HI 7'h04
`define A_EWDH_LO 7'h05
`define A_EWDL_HI 7'h06
`define A_EWDL_LO 7'h07
`define A_EWCS_HI 7'h08
`define A_EWCS_LO 7'h09
`define A_ERA_LO 7'h0B
`define A_ERCS_HI 7'h0C
`define A_ERCS_LO 7'h0D
`define A_ERDH_HI 7'h0E
`define A_ERDH_LO 7'h0F
`define A_ERDL_HI 7'h10
`define A_ERDL_LO 7'h11
`define A_CTRL_HI 7'h1E
`define A_CTRL_LO 7'h1F
`define A_KEY_HI 7'h3C
`define GO_BIT 7
`define DONE_BIT 0
`define BUSY_BIT 0
`define CONFIRM 8'hA5
`define SHADOW_OFS 8'h40
`define NV_WORDS 32
`define DATA_BITS 24
`define LOCK_ADDR 5'h1F
`define LOCK_NV 4'hC
`define LOCK_ALL 4'h3
`define MARGIN_LOW 4'h1
`define MARGIN_HIGH 4'h2
`define CLK_HZ 10000000
`define NV_WR_US 24000
`define NV_RD_NS 2000
`define NV_WR_CYC ((`NV_WR_US / 1000) * (`CLK_HZ / 1000))
`define NV_RD_CYC ((`NV_RD_NS * (`CLK_HZ / 1000000)) / 1000)
`endif

// File: src/eeprom_shadow_access_ctrl.v
// Purpose: extended access to nonvolatile store and its shadow copy
// Assumes: register port and store port share clk with this block
// Notes: store answers each request with a one-cycle ack
`include "eeprom_shadow_map.vh"
`default_nettype none
module eeprom_shadow_access_ctrl #(
   parameter WR_TIMEOUT = `NV_WR_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire regWrite,
   input wire regRead,
   input wire [6:0] regAddr,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   input wire clrFlags,
   output reg xeeWarn,
   output reg xeeErr,
   output reg nvReq,
   output reg nvWe,
   output reg [4:0] nvAddr,
   output reg [31:0] nvWdata,
   output reg [1:0] nvMargin,
   input wire nvAck,
   input wire [31:0] nvRdata,
   output wire bootDone
);
   localparam RD_TIMEOUT = `NV_RD_CYC;
   localparam S_BOOT = 6'b000001;
   localparam S_BWAIT = 6'b000010;
   localparam S_IDLE = 6'b000100;
   localparam S_NVWR = 6'b001000;
   localparam S_NVRD = 6'b010000;
   localparam S_DONE = 6'b100000;

   reg [5:0] state;
   reg [`DATA_BITS-1:0] shadow [0:`NV_WORDS-1];
   reg [7:0] wrAddr;
   reg [31:0] wrData;
   reg [7:0] rdAddr;
   reg [31:0] rdData;
   reg wrDone, rdDone, wrBusy, rdBusy;
   reg [3:0] lockCode;
   reg [2:0] keyStep;
   reg unlocked;
   reg [3:0] specialReq;
   reg [3:0] marginSel;
   reg [17:0] timer;
   reg [4:0] bootIdx;
   reg shWe;
   reg [4:0] shAddr;
   reg [`DATA_BITS-1:0] shData;

   // Byte of the unlock sequence expected at each step
   function [7:0] keyByte;
      input [2:0] step;
      begin
         case (step)
            3'd0: keyByte = 8'h00;
            3'd1: keyByte = 8'h27;
            3'd2: keyByte = 8'h81;
            3'd3: keyByte = 8'h1F;
            default: keyByte = 8'h77;
         endcase
      end
   endfunction

   // Nonvolatile range is 0x00..0x1F, shadow 0x40 above it
   function isNv;
      input [7:0] a;
      begin
         isNv = (a[7:5] == 3'b000);
      end
   endfunction

   function isShadow;
      input [7:0] a;
      begin
         isShadow = (a[7:5] == `SHADOW_OFS >> 5);
      end
   endfunction

   function [1:0] marginCode;
      input [3:0] sel;
      begin
         case (sel)
            `MARGIN_LOW: marginCode = 2'b01;
            `MARGIN_HIGH: marginCode = 2'b10;
            default: marginCode = 2'b00;
         endcase
      end
   endfunction

   wire wrGo = regWrite && regAddr == `A_EWCS_HI
      && regWdata[`GO_BIT]; // RL11
   wire rdGo = regWrite && regAddr == `A_ERCS_HI
      && regWdata[`GO_BIT]; // RL23

   // Code 0xC blocks the store only;
   // code 0x3 blocks store and shadow;
   // every other code leaves both open
   wire lockNv = lockCode == `LOCK_NV || lockCode == `LOCK_ALL; // RL8 RL9
   wire lockSh = lockCode == `LOCK_ALL; // RL9 RL25
   wire nvWrOk = unlocked && !lockNv && isNv(wrAddr);
   wire shWrOk = unlocked && !lockSh && isShadow(wrAddr); // RL4
   wire idle = state == S_IDLE;
   assign bootDone = !state[0] && !state[1];


   // Extended write flow, seen from this block:
   //   go bit taken only while idle
   //   store target: request held until ack or write timeout
   //   shadow target: word lands one edge after the go is taken
   //   anything else: done and warning at once
   // Extended read flow:
   //   store target: margin code frozen with request
   //   shadow target: data ready at once, with done
   // Lock code lives in store word 0x1F, bits 3:0
   // Lock copy follows a store write to that word,
   //   so later writes in the same session obey it
   //   without waiting for a power cycle
   // Limitation: a write timeout leaves the store
   //   word unknown; host must rewrite it
   // Key sequence restarts on any wrong byte
   // Margin code is loaded only when a store read starts
   // Flags: set wins over a same-cycle clear

   // Register writes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrAddr <= 8'h00;
         wrData <= 32'h0000_0000;
         rdAddr <= 8'h00;
         keyStep <= 3'd0;
         unlocked <= 1'b0; // RL26
         specialReq <= 4'h0;
         marginSel <= 4'h0; // RL21
      end else if (regWrite) begin
         case (regAddr)
            `A_EWA_LO: wrAddr <= regWdata; // RL10
            `A_EWDH_HI: wrData[31:24] <= regWdata;
            `A_EWDH_LO: wrData[23:16] <= regWdata;
            `A_EWDL_HI: wrData[15:8] <= regWdata;
            `A_EWDL_LO: wrData[7:0] <= regWdata;
            `A_ERA_LO: rdAddr <= regWdata;
            `A_CTRL_HI: specialReq <= regWdata[7:4];
            `A_CTRL_LO: begin
               // Settings other than margin codes are not kept
               if (regWdata == `CONFIRM) begin // RL20
                  if (specialReq == 4'h0)
                     marginSel <= 4'h0; // RL21
                  else if (unlocked && marginCode(specialReq) != 2'b00)
                     marginSel <= specialReq; // RL7 RL17 RL18 RL19
               end
            end
            `A_KEY_HI: begin
               // A wrong byte restarts; 0x00 may begin a new try
               if (regWdata == keyByte(keyStep)) begin // RL5
                  if (keyStep == 3'd4) begin
                     unlocked <= 1'b1;
                     keyStep <= 3'd0;
                  end else begin
                     keyStep <= keyStep + 3'd1;
                  end
               end else begin
                  keyStep <= (regWdata == 8'h00) ? 3'd1 : 3'd0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Shadow storage: written at boot or by an extended write
   always @(posedge clk) begin
      if (shWe)
         shadow[shAddr] <= shData;
   end


   // Transaction sequencer
   // Boot walks all words once; go bits are ignored
   // until the walk is over (bootDone)
   // Write and read timeouts give a stuck store a way out; boot has none
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_BOOT;
         bootIdx <= 5'd0;
         nvReq <= 1'b0;
         nvWe <= 1'b0;
         nvAddr <= 5'd0;
         nvWdata <= 32'h0000_0000;
         nvMargin <= 2'b00;
         timer <= 18'd0;
         lockCode <= 4'h0;
         wrDone <= 1'b0;
         rdDone <= 1'b0;
         wrBusy <= 1'b0;
         rdBusy <= 1'b0;
         rdData <= 32'h0000_0000;
         xeeWarn <= 1'b0;
         xeeErr <= 1'b0;
         shWe <= 1'b0;
         shAddr <= 5'd0;
         shData <= {`DATA_BITS{1'b0}};
      end else begin
         shWe <= 1'b0;
         if (clrFlags) begin
            xeeWarn <= 1'b0;
            xeeErr <= 1'b0;
         end
         case (state)
            S_BOOT: begin
               nvReq <= 1'b1;
               nvWe <= 1'b0;
               nvAddr <= bootIdx;
               nvMargin <= 2'b00;
               state <= S_BWAIT;
            end
            S_BWAIT: begin
               if (nvAck) begin
                  nvReq <= 1'b0;
                  shWe <= 1'b1; // RL1
                  shAddr <= bootIdx;
                  shData <= nvRdata[`DATA_BITS-1:0]; // RL3
                  if (bootIdx == `LOCK_ADDR)
                     lockCode <= nvRdata[3:0];
                  bootIdx <= bootIdx + 5'd1;
                  state <= (bootIdx == `NV_WORDS - 1) ? S_IDLE : S_BOOT;
               end
            end
            S_IDLE: begin
               if (wrGo) begin
                  wrDone <= 1'b0; // RL26
                  if (nvWrOk) begin
                     wrBusy <= 1'b1;
                     nvReq <= 1'b1;
                     nvWe <= 1'b1;
                     nvAddr <= wrAddr[4:0];
                     nvWdata <= wrData;
                     timer <= 18'd0;
                     state <= S_NVWR;
                  end else if (shWrOk) begin
                     shWe <= 1'b1; // RL13
                     shAddr <= wrAddr[4:0];
                     shData <= wrData[`DATA_BITS-1:0]; // RL3
                     state <= S_DONE;
                  end else begin
                     wrDone <= 1'b1; // RL15
                     xeeWarn <= 1'b1; // RL15
                  end
               end else if (rdGo) begin
                  rdDone <= 1'b0;
                  if (isNv(rdAddr)) begin // RL6
                     rdBusy <= 1'b1;
                     nvReq <= 1'b1;
                     nvWe <= 1'b0;
                     nvAddr <= rdAddr[4:0];
                     nvMargin <= marginCode(marginSel); // RL17 RL18
                     timer <= 18'd0;
                     state <= S_NVRD;
                  end else if (isShadow(rdAddr)) begin // RL2 RL4
                     rdData <= {8'h00, shadow[rdAddr[4:0]]}; // RL3
                     rdDone <= 1'b1;
                  end else begin
                     rdDone <= 1'b1; // RL15
                     xeeWarn <= 1'b1;
                  end
               end
            end
            S_NVWR: begin
               timer <= timer + 18'd1;
               if (nvAck) begin
                  nvReq <= 1'b0;
                  wrBusy <= 1'b0;
                  wrDone <= 1'b1; // RL12
                  if (nvAddr == `LOCK_ADDR)
                     lockCode <= nvWdata[3:0];
                  state <= S_IDLE;
               end else if (timer == WR_TIMEOUT - 1) begin
                  // Store gave no answer in time: abort
                  nvReq <= 1'b0;
                  wrBusy <= 1'b0;
                  wrDone <= 1'b1; // RL15
                  xeeWarn <= 1'b1;
                  xeeErr <= 1'b1; // RL16
                  state <= S_IDLE;
               end
            end
            S_NVRD: begin
               timer <= timer + 18'd1;
               if (nvAck) begin
                  nvReq <= 1'b0;
                  rdBusy <= 1'b0;
                  rdData <= nvRdata; // RL24
                  rdDone <= 1'b1; // RL24
                  state <= S_IDLE;
               end else if (timer == RD_TIMEOUT - 1) begin
                  nvReq <= 1'b0;
                  rdBusy <= 1'b0;
                  rdDone <= 1'b1; // RL15
                  xeeWarn <= 1'b1;
                  state <= S_IDLE;
               end
            end
            S_DONE: begin
               // Shadow word written on this same edge
               wrDone <= 1'b1; // RL13
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end


   // Register reads, any time and without unlocking
   // Busy flags sit in the low bit of the even byte,
   // done flags in the low bit of the odd byte
   // Unmapped reads return zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `A_EWA_LO: regRdata <= wrAddr;
            `A_EWDH_HI: regRdata <= wrData[31:24];
            `A_EWDH_LO: regRdata <= wrData[23:16];
            `A_EWDL_HI: regRdata <= wrData[15:8];
            `A_EWDL_LO: regRdata <= wrData[7:0];
            `A_EWCS_HI: regRdata <= {7'h00, wrBusy};
            `A_EWCS_LO: regRdata <= {7'h00, wrDone}; // RL14
            `A_ERA_LO: regRdata <= rdAddr;
            `A_ERCS_HI: regRdata <= {7'h00, rdBusy};
            `A_ERCS_LO: regRdata <= {7'h00, rdDone};
            `A_ERDH_HI: regRdata <= rdData[31:24];
            `A_ERDH_LO: regRdata <= rdData[23:16];
            `A_ERDL_HI: regRdata <= rdData[15:8];
            `A_ERDL_LO: regRdata <= rdData[7:0];
            `A_CTRL_HI: regRdata <= {marginSel, 4'h0}; // RL19
            default: regRdata <= 8'h00;
         endcase
      end
   end
endmodule // eeprom_shadow_access_ctrl
`default_nettype wire

// File: dv/store_model.sv
// Purpose: behavioural nonvolatile store behind the access block
// Assumes: one request at a time, acked by a one-cycle pulse
// Notes: word 7 holds weak cells that flip under the margin thresholds
`default_nettype none
module store_model #(
   parameter int LAT = 4
) (
   input wire logic clk,
   input wire logic nvReq,
   input wire logic nvWe,
   input wire logic [4:0] nvAddr,
   input wire logic [31:0] nvWdata,
   input wire logic [1:0] nvMargin,
   input wire logic stall,
   output logic nvAck,
   output logic [31:0] nvRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [32];
   logic [31:0] word;
   int cnt;
   initial begin
      for (int i = 0; i < 32; i++)
         mem[i] = 32'hA5C3_1300 + i;
      nvAck = 1'b0;
      nvRdata = 32'h0000_0000;
      cnt = 0;
   end
   always @(posedge clk) begin
      nvAck <= 1'b0;
      // Read data is only good with the ack, never a stale copy
      nvRdata <= ~nvRdata;
      if (!nvReq || nvAck)
         cnt <= 0;
      else if (!stall)
         cnt <= cnt + 1;
      if (nvReq && !nvAck && !stall && cnt == LAT) begin
         nvAck <= 1'b1;
         word = mem[nvAddr];
         if (nvMargin == 2'b01 && nvAddr == 5'd7)
            word = word | 32'h0000_0010;
         if (nvMargin == 2'b10 && nvAddr == 5'd7)
            word = word & ~32'h0000_0100;
         nvRdata <= word;
         if (nvWe)
            mem[nvAddr] <= nvWdata;
      end
   end
endmodule // store_model
`default_nettype wire

// File: dv/eeprom_shadow_access_ctrl_chk.sv
// Purpose: port-level checks of the extended access block
// Assumes: single clock domain, async active-low reset
// Notes: attached by bind at the foot of this file
`default_nettype none
module eeprom_shadow_access_ctrl_chk #(
   parameter WR_TIMEOUT = 50
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [6:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic clrFlags,
   input wire logic xeeWarn,
   input wire logic xeeErr,
   input wire logic nvReq,
   input wire logic nvWe,
   input wire logic [4:0] nvAddr,
   input wire logic [31:0] nvWdata,
   input wire logic [1:0] nvMargin,
   input wire logic nvAck,
   input wire logic [31:0] nvRdata,
   input wire logic bootDone
);
   timeunit 1ns;
   timeprecision 1ns;
   int wrCnt;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wrCnt <= 0;
      else if (nvReq && nvWe && !nvAck)
         wrCnt <= wrCnt + 1;
      else
         wrCnt <= 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_REQ_HOLD: assert property (nvReq && !nvAck |=> !nvReq || ($stable(nvAddr)
      && $stable(nvWe) && $stable(nvWdata) && $stable(nvMargin)))
      else $error("store request changed while pending");
   AST_ACK_ENDS: assert property (nvReq && nvAck && bootDone |=> !nvReq)
      else $error("store request outlived its ack");
   AST_WR_BOUND: assert property (wrCnt <= WR_TIMEOUT + 1)
      else $error("store write ran past its timeout");
   AST_ABORT_ERR: assert property ($fell(nvReq) && $past(nvWe) && !$past(nvAck)
      |-> ##[0:2] xeeErr)
      else $error("aborted write left error clear");
   AST_ERR_CAUSE: assert property ($rose(xeeErr) |-> $past(nvReq && nvWe))
      else $error("error rose without a pending write");
   AST_ERR_WARN: assert property ($rose(xeeErr) |-> ##[0:1] xeeWarn)
      else $error("abort raised no warning");
   AST_MARGIN_CONFIRM: assert property ($changed(nvMargin) |->
      $rose(nvReq) && !nvWe)
      else $error("margin changed outside a store read start");
   AST_MARGIN_CODE: assert property (nvMargin != 2'b11)
      else $error("illegal margin code");
   AST_FLAG_CLEAR: assert property (clrFlags && !nvReq && !regWrite &&
      !$past(regWrite) |=> !xeeWarn && !xeeErr)
      else $error("flags not cleared");
   AST_BOOT_STAYS: assert property (bootDone |=> bootDone)
      else $error("boot done dropped");
   AST_RDATA_HOLD: assert property (!regRead |=> $stable(regRdata))
      else $error("read byte changed without a read");
   cover property ($rose(xeeErr));
   cover property (nvMargin == 2'b01);
   cover property (nvMargin == 2'b10);
   cover property (nvReq && nvWe && nvAck);
endmodule // eeprom_shadow_access_ctrl_chk
bind eeprom_shadow_access_ctrl eeprom_shadow_access_ctrl_chk #(
   .WR_TIMEOUT(WR_TIMEOUT)) chk_inst (.clk(clk), .rst_n(rst_n),
   .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
   .regWdata(regWdata), .regRdata(regRdata), .clrFlags(clrFlags),
   .xeeWarn(xeeWarn), .xeeErr(xeeErr), .nvReq(nvReq), .nvWe(nvWe),
   .nvAddr(nvAddr), .nvWdata(nvWdata), .nvMargin(nvMargin),
   .nvAck(nvAck), .nvRdata(nvRdata), .bootDone(bootDone));
`default_nettype wire

// File: dv/test_eeprom_shadow_access_ctrl.sv
// Purpose: register-level tests of the extended access block
// Assumes: store model answers after a few cycles unless stalled
// Notes: write timeout shortened to keep the run short
`default_nettype none
module test_eeprom_shadow_access_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, regWrite, regRead, clrFlags, stall;
   logic xeeWarn, xeeErr, nvReq, nvWe, nvAck, bootDone;
   logic [6:0] regAddr;
   logic [7:0] regWdata, regRdata, b;
   logic [4:0] nvAddr;
   logic [31:0] nvWdata, nvRdata, got;
   logic [1:0] nvMargin;
   logic [7:0] codes [3] = '{8'h10, 8'h20, 8'h00};
   logic [31:0] marg [3] = '{32'hA5C3_1317, 32'hA5C3_1207, 32'hA5C3_1307};
   int mismatches, n_checks, polls;
   eeprom_shadow_access_ctrl #(.WR_TIMEOUT(50)) eeprom_shadow_access_ctrl_inst (
      .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .clrFlags(clrFlags), .xeeWarn(xeeWarn), .xeeErr(xeeErr), .nvReq(nvReq),
      .nvWe(nvWe), .nvAddr(nvAddr), .nvWdata(nvWdata), .nvMargin(nvMargin),
      .nvAck(nvAck), .nvRdata(nvRdata), .bootDone(bootDone));
   store_model store_model_inst (.clk(clk), .nvReq(nvReq), .nvWe(nvWe),
      .nvAddr(nvAddr), .nvWdata(nvWdata), .nvMargin(nvMargin), .stall(stall),
      .nvAck(nvAck), .nvRdata(nvRdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      d = regRdata;
   endtask
   task automatic poll(input logic [6:0] a);
      logic [7:0] s;
      s = 8'h00;
      polls = 0;
      for (int i = 0; i < 200 && s[0] !== 1'b1; i++) begin
         rd(a, s);
         polls++;
      end
      chk({31'b0, s[0]}, 1);
   endtask
   task automatic xw(input logic [7:0] a, input logic [31:0] d);
      wr(7'h03, a);
      for (int i = 0; i < 4; i++)
         wr(7'(4 + i), d[31 - 8 * i -: 8]);
      wr(7'h08, 8'h80);
      poll(7'h09);
   endtask
   task automatic xr(input logic [7:0] a, output logic [31:0] d);
      logic [7:0] s;
      wr(7'h0B, a);
      wr(7'h0C, 8'h80);
      poll(7'h0D);
      for (int i = 0; i < 4; i++) begin
         rd(7'(14 + i), s);
         d = {d[23:0], s};
      end
   endtask
   task automatic key(input logic [7:0] k [5]);
      foreach (k[i])
         wr(7'h3C, k[i]);
   endtask
   task automatic clr();
      @(negedge clk);
      clrFlags = 1'b1;
      @(negedge clk);
      clrFlags = 1'b0;
   endtask
   task automatic fl(input logic [1:0] e);
      chk({30'b0, xeeWarn, xeeErr}, {30'b0, e});
   endtask
   task automatic reset_dut();
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 1000 && bootDone !== 1'b1; i++)
         @(negedge clk);
      chk({31'b0, bootDone}, 1);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #(20000 * 100);
      mismatches++;
      close_out();
   end
   initial begin
      {rst_n, regWrite, regRead, clrFlags, stall} = 5'b0;
      {regAddr, regWdata, mismatches, n_checks} = '0;
      reset_dut();
      xr(8'h42, got);
      chk(got, 32'h00C3_1302);
      xr(8'h05, got);
      chk(got, 32'hA5C3_1305);
      fl(2'b00);
      xw(8'h45, 32'hFFAA_BBCC);
      fl(2'b10);
      xr(8'h45, got);
      chk(got, 32'h00C3_1305);
      $display("boot and locked access test done");
      clr();
      key('{8'h00, 8'h27, 8'h81, 8'h1F, 8'h76});
      xw(8'h45, 32'hFFAA_BBCC);
      fl(2'b10);
      clr();
      key('{8'h00, 8'h27, 8'h81, 8'h1F, 8'h77});
      xw(8'h45, 32'hFFAA_BBCC);
      chk(polls, 1);
      xr(8'h45, got);
      chk(got, 32'h00AA_BBCC);
      xw(8'h06, 32'h00A4_5678);
      chk(32'(polls > 1), 1);
      xr(8'h06, got);
      chk(got, 32'h00A4_5678);
      fl(2'b00);
      $display("unlock and write test done");
      wr(7'h1E, 8'h10);
      rd(7'h1E, b);
      chk({24'b0, b}, 0);
      for (int i = 0; i < 3; i++) begin
         wr(7'h1E, codes[i]);
         wr(7'h1F, 8'hA5);
         rd(7'h1E, b);
         chk({24'b0, b}, {24'b0, codes[i]});
         xr(8'h07, got);
         chk(got, marg[i]);
      end
      $display("margin test done");
      stall = 1'b1;
      xw(8'h08, 32'h0000_1234);
      stall = 1'b0;
      fl(2'b11);
      $display("write abort test done");
      clr();
      xw(8'h1F, 32'h0000_000C);
      xw(8'h06, 32'h1111_1111);
      fl(2'b10);
      xr(8'h06, got);
      chk(got, 32'h00A4_5678);
      clr();
      xw(8'h46, 32'h0012_3456);
      fl(2'b00);
      reset_dut();
      wr(7'h1E, 8'h10);
      wr(7'h1F, 8'hA5);
      rd(7'h1E, b);
      chk({24'b0, b}, 0);
      xw(8'h46, 32'h0012_3456);
      fl(2'b10);
      store_model_inst.mem[31] = 32'h0000_0003;
      reset_dut();
      key('{8'h00, 8'h27, 8'h81, 8'h1F, 8'h77});
      xw(8'h46, 32'h0055_5555);
      fl(2'b10);
      xr(8'h46, got);
      chk(got, 32'h00A4_5678);
      $display("write lock test done");
      close_out();
   end
endmodule // test_eeprom_shadow_access_ctrl
`default_nettype wire
